// *** shared/i2csw_pkg.sv ***
// shared constants and the pointer step function for the two-wire switch register access block
package i2csw_pkg;
  localparam int unsigned       I2CSW_NUM_REGS      = 7;       // registers readable in enhanced mode
  localparam int unsigned       I2CSW_NUM_WR_REGS   = 3;       // registers writable in enhanced mode
  localparam logic [2:0]        I2CSW_PTR_FIRST     = 3'h0;    // switch control register index
  localparam logic [2:0]        I2CSW_PTR_LAST_RD   = 3'h6;    // last readable register index
  localparam logic [2:0]        I2CSW_PTR_LAST_WR   = 3'h2;    // last writable register index
  localparam logic [7:0]        I2CSW_REG_RESET     = 8'h00;   // reset value of every writable register
  localparam logic [6:0]        I2CSW_DEV_ADDR      = 7'h70;   // default slave address, arbitrary
  localparam int unsigned       I2CSW_CLK_HZ        = 100_000_000;
  localparam int unsigned       I2CSW_SCL_HZ        = 400_000; // master bus clock rate, fast rate keeps runs short
  // quarter period of the bus clock in system cycles
  localparam int unsigned       I2CSW_QTR_CYC       = I2CSW_CLK_HZ / (I2CSW_SCL_HZ * 4);
  localparam logic              I2CSW_RW_WRITE      = 1'b0;    // direction bit for write
  localparam logic              I2CSW_RW_READ       = 1'b1;    // direction bit for read

  // register pointer step, wraps to switch control after the last index
  function automatic logic [2:0] i2csw_next_ptr(input logic [2:0] p, input logic [2:0] last);
    i2csw_next_ptr = (p == last) ? I2CSW_PTR_FIRST : 3'(p + 3'h1);
  endfunction
endpackage

// *** shared/i2csw_if.sv ***
// two-wire bus between the master end and the switch end
`timescale 1ns/1ns
interface i2csw_if;
  logic scl_o;    // master scl output value
  logic scl_oe;   // master drives scl low
  logic sda_m_o;  // master sda output value
  logic sda_m_oe; // master drives sda low
  logic sda_s_o;  // slave sda output value
  logic sda_s_oe; // slave drives sda low
  wire  scl;      // resolved wired-and clock
  wire  sda;      // resolved wired-and data
  // open-drain resolution with pull-ups
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport slave  (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface

// *** rtl/i2csw_slave.sv ***
// switch end: two-wire slave with switch control and enhanced registers
`timescale 1ns/1ns
// Summary of operation
// - basic mode reaches only switch control
// - single written byte loads switch control
// - basic multi-byte write keeps last byte
// - basic mode acks bytes, commits at stop
// - master writes begin with address, rw low
// - device acknowledges its own address always
// - stop after address ack is complete
// - device acknowledges every written data byte
// - enhanced write starts at control, increments
// - enhanced write commits each byte immediately
// - master reads begin with address, rw high
// - basic single read returns switch control
// - basic multi read repeats switch control
// - master acks each byte to continue reading
// - enhanced read starts at control, ascends
// - enhanced read wraps after seven registers
// - enhanced write cycles three writable registers
// - pointer restarts at control each transaction
module i2csw_slave
  import i2csw_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  i2csw_if.slave          bus,
  input  wire logic [6:0] dev_addr,
  input  wire logic       enhanced,
  input  wire logic [7:0] stat_in [4],
  output logic [7:0]      sw_ctrl,
  output logic [7:0]      cfg_reg,
  output logic [7:0]      flush_reg,
  output logic            busy
);
  typedef enum logic [2:0] {
    I2CSW_IDLE = 3'b000, // waiting for start
    I2CSW_ADDR = 3'b001, // shifting address byte
    I2CSW_AACK = 3'b011, // address acknowledge slot
    I2CSW_WDAT = 3'b010, // receiving data byte
    I2CSW_WACK = 3'b110, // data acknowledge slot
    I2CSW_RDAT = 3'b111, // sending data byte
    I2CSW_RACK = 3'b101  // master acknowledge slot
  } i2csw_st_e;

  logic [1:0]  scl_sync_q;   // two-stage scl synchroniser
  logic [1:0]  sda_sync_q;   // two-stage sda synchroniser
  logic        scl_d1_q;     // previous synced scl
  logic        sda_d1_q;     // previous synced sda
  i2csw_st_e   st_q;         // protocol state
  logic [3:0]  bit_q;        // bit counter in byte
  logic [7:0]  sh_q;         // receive shift register
  logic [7:0]  tx_q;         // transmit byte
  logic        rw_q;         // direction of transaction
  logic [2:0]  ptr_q;        // register pointer
  logic [7:0]  pend_q;       // basic mode pending byte
  logic        pend_v_q;     // pending byte present
  logic [7:0]  regs_q [3];   // writable registers
  logic        sda_oe_q;     // drive sda low
  logic        busy_q;       // addressed transaction flag
  logic [2:0]  ptr_nx;       // next read pointer, enhanced walk
  logic [7:0]  rd_cur;       // byte at the current pointer
  logic [7:0]  rd_nx;        // byte at the next read pointer

  wire scl_s   = scl_sync_q[1];
  wire sda_s   = sda_sync_q[1];
  wire scl_r   = scl_s & ~scl_d1_q;               // rising edge of scl
  wire scl_f   = ~scl_s & scl_d1_q;               // falling edge of scl
  wire start_c = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  wire stop_c  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;

  // read mux, basic mode only shows switch control
  function automatic logic [7:0] rd_mux(input logic [2:0] p, input logic enh);
    if (!enh || p == I2CSW_PTR_FIRST)
      rd_mux = regs_q[0];
    else if (p < 3'(I2CSW_NUM_WR_REGS))
      rd_mux = regs_q[p[1:0]];
    else
      rd_mux = stat_in[2'(p - 3'(I2CSW_NUM_WR_REGS))];
  endfunction

  // read bytes for the first and the following data slots
  always_comb begin
    ptr_nx = i2csw_next_ptr(ptr_q, I2CSW_PTR_LAST_RD);
    rd_cur = rd_mux(ptr_q, enhanced);
    rd_nx  = rd_mux(ptr_nx, 1'b1);
  end

  // synchronise the bus pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_d1_q   <= 1'b1;
      sda_d1_q   <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_d1_q   <= scl_s;
      sda_d1_q   <= sda_s;
    end
  end

  // protocol sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q     <= I2CSW_IDLE;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      rw_q     <= 1'b0;
      ptr_q    <= I2CSW_PTR_FIRST;
      sda_oe_q <= 1'b0;
      busy_q   <= 1'b0;
    end else if (start_c) begin
      // new or repeated start
      st_q     <= I2CSW_ADDR;
      bit_q    <= 4'h0;
      ptr_q    <= I2CSW_PTR_FIRST;
      sda_oe_q <= 1'b0;
      busy_q   <= 1'b0;
    end else if (stop_c) begin
      st_q     <= I2CSW_IDLE;
      sda_oe_q <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      unique case (st_q)
        I2CSW_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        I2CSW_ADDR: begin
          if (scl_r) begin
            sh_q  <= {sh_q[6:0], sda_s};
            bit_q <= 4'(bit_q + 4'h1);
          end else if (scl_f && bit_q == 4'h8) begin
            if (sh_q[7:1] == dev_addr) begin
              // own address, acknowledge either direction
              sda_oe_q <= 1'b1;
              rw_q     <= sh_q[0];
              busy_q   <= 1'b1;
              st_q     <= I2CSW_AACK;
            end else begin
              st_q <= I2CSW_IDLE;                // not ours
            end
          end
        end
        I2CSW_AACK: begin
          if (scl_f) begin
            bit_q <= 4'h0;
            if (rw_q == I2CSW_RW_READ) begin
              tx_q     <= {rd_cur[6:0], 1'b0};
              sda_oe_q <= ~rd_cur[7];
              st_q     <= I2CSW_RDAT;
            end else begin
              sda_oe_q <= 1'b0;
              st_q     <= I2CSW_WDAT;
            end
          end
        end
        I2CSW_WDAT: begin
          if (scl_r) begin
            sh_q  <= {sh_q[6:0], sda_s};
            bit_q <= 4'(bit_q + 4'h1);
          end else if (scl_f && bit_q == 4'h8) begin
            sda_oe_q <= 1'b1;
            st_q     <= I2CSW_WACK;
            if (enhanced)
              ptr_q <= i2csw_next_ptr(ptr_q, I2CSW_PTR_LAST_WR);
          end
        end
        I2CSW_WACK: begin
          if (scl_f) begin
            sda_oe_q <= 1'b0;
            bit_q    <= 4'h0;
            st_q     <= I2CSW_WDAT;
          end
        end
        I2CSW_RDAT: begin
          if (scl_f) begin
            if (bit_q == 4'h7) begin
              sda_oe_q <= 1'b0;                  // release for master ack
              st_q     <= I2CSW_RACK;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q     <= {tx_q[6:0], 1'b0};
              bit_q    <= 4'(bit_q + 4'h1);
            end
          end
        end
        I2CSW_RACK: begin
          if (scl_r && sda_s) begin
            st_q <= I2CSW_IDLE;                  // master nack ends reading
          end else if (scl_f) begin
            // master acked, next byte
            bit_q <= 4'h0;
            if (enhanced) begin
              ptr_q    <= ptr_nx;
              tx_q     <= {rd_nx[6:0], 1'b0};
              sda_oe_q <= ~rd_nx[7];
            end else begin
              tx_q     <= {regs_q[0][6:0], 1'b0};
              sda_oe_q <= ~regs_q[0][7];
            end
            st_q <= I2CSW_RDAT;
          end
        end
        default: st_q <= I2CSW_IDLE;
      endcase
    end
  end

  // register updates and basic-mode pending byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regs_q[0] <= I2CSW_REG_RESET;
      regs_q[1] <= I2CSW_REG_RESET;
      regs_q[2] <= I2CSW_REG_RESET;
      pend_q    <= I2CSW_REG_RESET;
      pend_v_q  <= 1'b0;
    end else if (start_c) begin
      pend_v_q <= 1'b0;
    end else if (stop_c) begin
      if (pend_v_q)
        regs_q[0] <= pend_q;
      pend_v_q <= 1'b0;
    end else if (st_q == I2CSW_WDAT && scl_f && bit_q == 4'h8) begin
      if (enhanced)
        regs_q[ptr_q[1:0]] <= sh_q;
      else begin
        pend_q   <= sh_q;
        pend_v_q <= 1'b1;
      end
    end
  end

  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = sda_oe_q;
  assign sw_ctrl      = regs_q[0];
  assign cfg_reg      = regs_q[1];
  assign flush_reg    = regs_q[2];
  assign busy         = busy_q;
endmodule

// *** rtl/i2csw_master.sv ***
// host end: two-wire master issuing byte writes and reads
`timescale 1ns/1ns
module i2csw_master
  import i2csw_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  i2csw_if.master         bus,
  input  wire logic       req,
  input  wire logic [6:0] addr,
  input  wire logic       rw,
  input  wire logic [3:0] nbytes,
  input  wire logic [7:0] wdata [8],
  output logic            done,
  output logic            acked,
  output logic [7:0]      rdata [8]
);
  typedef enum logic [2:0] {
    I2CSW_M_IDLE  = 3'b000,
    I2CSW_M_START = 3'b001,
    I2CSW_M_BIT   = 3'b011,
    I2CSW_M_STOP  = 3'b010
  } i2csw_mst_e;

  logic [15:0] div_q;       // quarter-period divider
  logic [1:0]  ph_q;        // phase within a bit
  i2csw_mst_e  st_q;        // master state
  logic [3:0]  bit_q;       // bit in byte, 8 is ack
  logic [3:0]  byte_q;      // byte index, 0 is address
  logic [3:0]  nb_q;        // bytes requested
  logic        rw_q;        // captured direction
  logic [7:0]  sh_q;        // byte being moved
  logic        scl_oe_q;    // pull scl low
  logic        sda_oe_q;    // pull sda low
  logic        done_q;      // completion pulse
  logic        ack_q;       // address acknowledged
  logic [1:0]  sda_sync_q;  // two-stage sda synchroniser
  logic [7:0]  rd_q [8];    // read bytes
  wire         tick = (div_q == 16'(I2CSW_QTR_CYC - 1));

  // sda synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) sda_sync_q <= 2'b11;
    else sda_sync_q <= {sda_sync_q[0], bus.sda};
  end

  // quarter-period enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) div_q <= 16'h0000;
    else div_q <= tick ? 16'h0000 : 16'(div_q + 16'h0001);
  end

  // bit engine: phase 0 low set data, 1 raise, 2 sample, 3 lower
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q     <= I2CSW_M_IDLE;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      byte_q   <= 4'h0;
      nb_q     <= 4'h0;
      rw_q     <= 1'b0;
      sh_q     <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q   <= 1'b0;
      ack_q    <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        rd_q[i] <= 8'h00;
      end
    end else begin
      done_q <= 1'b0;
      if (st_q == I2CSW_M_IDLE) begin
        if (req) begin
          st_q   <= I2CSW_M_START;
          ph_q   <= 2'h0;
          nb_q   <= nbytes;
          rw_q   <= rw;
          sh_q   <= {addr, rw};
          byte_q <= 4'h0;
          bit_q  <= 4'h0;
          ack_q  <= 1'b0;
        end
      end else if (tick) begin
        ph_q <= 2'(ph_q + 2'h1);
        unique case (st_q)
          I2CSW_M_START: begin
            if (ph_q == 2'h1) begin
              sda_oe_q <= 1'b1;                  // sda falls with scl high
            end
            if (ph_q == 2'h3) begin
              scl_oe_q <= 1'b1;
              st_q     <= I2CSW_M_BIT;
            end
          end
          I2CSW_M_BIT: begin
            unique case (ph_q)
              2'h0: begin
                if (bit_q == 4'h8) begin
                  // ack slot: master acks reads until the last byte
                  sda_oe_q <= (byte_q != 4'h0) && rw_q && (byte_q < nb_q);
                end else if (byte_q != 4'h0 && rw_q) begin
                  sda_oe_q <= 1'b0;              // switch end drives read bits
                end else begin
                  sda_oe_q <= ~sh_q[7];
                end
              end
              2'h1: begin
                scl_oe_q <= 1'b0;
              end
              2'h2: begin
                if (bit_q == 4'h8) begin
                  if (byte_q == 4'h0) begin
                    ack_q <= ~sda_sync_q[1];
                  end
                end else begin
                  sh_q <= {sh_q[6:0], sda_sync_q[1]};
                end
              end
              2'h3: begin
                scl_oe_q <= 1'b1;
                if (bit_q == 4'h8) begin
                  bit_q  <= 4'h0;
                  byte_q <= 4'(byte_q + 4'h1);
                  if (byte_q != 4'h0 && rw_q) begin
                    rd_q[3'(byte_q - 4'h1)] <= sh_q;
                  end
                  if (byte_q == nb_q || (byte_q == 4'h0 && !ack_q) || byte_q == 4'h8) begin
                    st_q <= I2CSW_M_STOP;
                  end else if (!rw_q) begin
                    sh_q <= wdata[3'(byte_q)];
                  end
                end else begin
                  bit_q <= 4'(bit_q + 4'h1);
                end
              end
            endcase
          end
          I2CSW_M_STOP: begin
            if (ph_q == 2'h0) begin
              sda_oe_q <= 1'b1;                  // data low before the clock rises
            end
            if (ph_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end
            if (ph_q == 2'h3) begin
              sda_oe_q <= 1'b0;                  // data rises with clock high
              st_q     <= I2CSW_M_IDLE;
              done_q   <= 1'b1;
            end
          end
          default: st_q <= I2CSW_M_IDLE;
        endcase
      end
    end
  end

  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = scl_oe_q;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = sda_oe_q;
  assign done         = done_q;
  assign acked        = ack_q;
  assign rdata        = rd_q;
endmodule

// *** bench/i2csw_assertions.sv ***
// assertion checker watching the two-wire link and the switch registers
`timescale 1ns/1ns
module i2csw_assertions (
  input wire logic       clock,     // system clock
  input wire logic       rst,       // async reset, active high
  input wire             scl,       // resolved bus clock
  input wire             sda,       // resolved bus data
  input wire logic       sda_s_oe,  // switch end pulls data low
  input wire logic       enhanced,  // mode select
  input wire logic       busy,      // switch end inside a transaction
  input wire logic [7:0] sw_ctrl,   // register 0
  input wire logic [7:0] cfg_reg,   // register 1
  input wire logic [7:0] flush_reg, // register 2
  input wire logic       done       // master end finished
);
  // single domain, reset silences every check
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // basic mode keeps control value until the stop ends the transaction
  a_basic_stop_commit: assert property (!enhanced && busy |=> $stable(sw_ctrl) || !busy)
    else $error("control value changed before stop");
  // basic mode never reaches registers beyond control
  a_basic_ctrl_only: assert property (!enhanced |=> $stable(cfg_reg) && $stable(flush_reg))
    else $error("hidden register written in basic mode");
  // enhanced writes to control and config land while the transaction is still open
  a_enh_live_update: assert property (enhanced && ($changed(sw_ctrl) || $changed(cfg_reg)) |-> busy)
    else $error("enhanced register written outside transaction");
  // switch end starts driving only in the low clock phase
  a_ack_low_phase: assert property ($rose(sda_s_oe) |-> !scl)
    else $error("switch drove data while clock high");
  // data from the switch end holds through the high phase
  a_data_steady: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("switch data moved while clock high");
  // completion flag is a single pulse
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  // both lines free once a transaction completes
  a_done_bus_free: assert property (done |-> scl && sda)
    else $error("bus not released at completion");
  // transaction closes only on a bus condition with clock high
  a_busy_end_cond: assert property ($fell(busy) |-> scl && $past(scl, 3))
    else $error("transaction closed with clock low");
endmodule

// *** bench/i2c_switch_register_access_tb.sv ***
// self-checking bench joining the master end and the switch end
`timescale 1ns/1ns
module i2c_switch_register_access_tb
  import i2csw_pkg::*;
;
  // one expected completion
  typedef struct {
    logic       ack;    // address acknowledge expected
    int         n;      // read bytes to compare
    logic [7:0] rd [8]; // expected read bytes
    logic [7:0] r [3];  // registers 0..2 after completion
  } i2csw_exp_s;

  logic        clock    = 1'b0;
  logic        rst      = 1'b1;
  logic        req      = 1'b0;
  logic [6:0]  addr     = 7'h00;
  logic        rw       = 1'b0;
  logic        enhanced = 1'b0;
  logic [3:0]  nbytes   = 4'h0;
  logic [7:0]  wdata [8];
  logic [7:0]  stat_in [4];
  logic [7:0]  rdata [8];
  logic [7:0]  sw_ctrl;
  logic [7:0]  cfg_reg;
  logic [7:0]  flush_reg;
  logic        done;
  logic        acked;
  logic        busy;
  logic [7:0]  m_reg [7];  // register model
  i2csw_exp_s  exp_q [$];  // notes from driver to monitor
  i2csw_exp_s  me;         // note under comparison
  int          n_fail   = 0;
  int          checks   = 0;
  int          cycles   = 0;
  integer      seed     = 32'hea92;

  i2csw_if bus_if ();

  i2csw_master i2csw_master_inst (.clock, .rst, .bus(bus_if), .req, .addr, .rw, .nbytes, .wdata,
                                  .done, .acked, .rdata);
  i2csw_slave i2csw_slave_inst (.clock, .rst, .bus(bus_if), .dev_addr(I2CSW_DEV_ADDR), .enhanced,
                                .stat_in, .sw_ctrl, .cfg_reg, .flush_reg, .busy);
  i2csw_assertions i2csw_assertions_inst (.clock, .rst, .scl(bus_if.scl), .sda(bus_if.sda),
                                          .sda_s_oe(bus_if.sda_s_oe), .enhanced, .busy, .sw_ctrl,
                                          .cfg_reg, .flush_reg, .done);

  // free-running clock
  always #5 clock = ~clock;

  // compare one value, count and report
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask

  // report counts and verdict, then stop
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard, about a fifth above the planned run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 88_000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // one transaction: note expectation, request, wait for completion
  task automatic xfer(input logic en, input logic r, input int n, input logic [6:0] a);
    i2csw_exp_s e;
    int         i;
    enhanced = en;
    rw       = r;
    nbytes   = 4'(n);
    addr     = a;
    e.ack    = (a == I2CSW_DEV_ADDR);
    e.n      = r ? n : 0;
    for (i = 0; i < 8; i++) begin
      wdata[i] = 8'($random(seed));
      e.rd[i]  = 8'h00;
    end
    // writes: basic repeats register 0, enhanced cycles 0..2
    if (e.ack && !r) begin
      for (i = 0; i < n; i++) begin
        m_reg[en ? i % 3 : 0] = wdata[i];
      end
    end
    // reads: basic repeats register 0, enhanced walks 0..6 and wraps
    for (i = 0; i < n; i++) begin
      e.rd[i] = m_reg[en ? i % 7 : 0];
    end
    for (i = 0; i < 3; i++) begin
      e.r[i] = m_reg[i];
    end
    exp_q.push_back(e);
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    while (done !== 1'b1) begin
      @(negedge clock);
    end
    @(negedge clock);
  endtask

  // monitor: take oldest note at each completion
  always @(posedge clock) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("note", 8'h01, 8'h00);
      end else begin
        me = exp_q.pop_front();
        check("acked", 8'(acked), 8'(me.ack));
        for (int i = 0; i < me.n; i++) begin
          check("rdata", rdata[i], me.rd[i]);
        end
        // stop reaches the switch end through its synchroniser after done
        repeat (4) @(posedge clock);
        check("sw_ctrl", sw_ctrl, me.r[0]);
        check("cfg_reg", cfg_reg, me.r[1]);
        check("flush_reg", flush_reg, me.r[2]);
      end
    end
  end

  // main sequence
  initial begin
    for (int i = 0; i < 8; i++) begin
      wdata[i] = 8'h00;
    end
    for (int i = 0; i < 3; i++) begin
      m_reg[i] = I2CSW_REG_RESET;
    end
    for (int i = 0; i < 4; i++) begin
      stat_in[i]   = 8'($random(seed));
      m_reg[3 + i] = stat_in[i];
    end
    repeat (5) @(negedge clock);
    rst = 1'b0;
    xfer(1'b0, I2CSW_RW_WRITE, 2, I2CSW_DEV_ADDR);
    xfer(1'b0, I2CSW_RW_READ, 2, I2CSW_DEV_ADDR);
    xfer(1'b0, I2CSW_RW_WRITE, 1, I2CSW_DEV_ADDR);
    xfer(1'b0, I2CSW_RW_READ, 1, I2CSW_DEV_ADDR);
    xfer(1'b0, I2CSW_RW_WRITE, 0, I2CSW_DEV_ADDR);
    xfer(1'b0, I2CSW_RW_WRITE, 0, I2CSW_DEV_ADDR ^ 7'h01);
    xfer(1'b1, I2CSW_RW_WRITE, 4, I2CSW_DEV_ADDR);
    xfer(1'b0, I2CSW_RW_READ, 3, I2CSW_DEV_ADDR);
    xfer(1'b1, I2CSW_RW_READ, 8, I2CSW_DEV_ADDR);
    // let the monitor finish the last note before the verdict
    repeat (8) @(negedge clock);
    check("notes_left", 8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule
